// *** hw/tscw_pkg.sv ***
// Constants, field positions and types of the terminal status control word.
// Assumes one 250 MHz clock, an AHB-Lite register slave and a host
// controller that writes the control word and issues entry-copy commands.
// Operation
// - Clock entries 247 to 253 follow the timekeeper; overwrites are ignored.
// - A copy command moves a clock entry value into a mapped word.
// - Entry 248 shows current minutes, entry 249 current hours.
// - Bit 11 rising clears display history, then bit 11 returns to zero.
// - Monochrome: bits 10,8 select white/red, flashing/steady when display on.
// - Colour variant ignores bit 10; bit 8 selects flashing or steady white.
// - Bit 15 zero turns backlight off, colour and mode ignored.
// - Bit 7 rising starts printing the shown screen; no abort exists.
// - Once printing and busy is set, bit 7 is cleared to zero.
// - Bit 6 one closes windows and refuses opening new ones.
// - Bit 5 one blocks numeric, string and thumbwheel entry.
// - Control word is not sampled at start-up; only later changes act; here only history and print ignore the first write.
// - Bit 13 continuous, bit 12 intermittent buzzer; both clear stops it.
// - A buzzer-stop touch key silences a sounding buzzer.
// - Buzzer sounds only when the stored buzzer switch permits it.
package tscw_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ      = 250;
   localparam int TICK_MS      = 1000;
   localparam int TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
   localparam int BLINK_MS     = 500;
   localparam int BLINK_CYCLES = BLINK_MS * 1000 * CLK_MHZ;
   localparam int TICK_W       = 28;
   localparam int BLINK_W      = 27;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STAT = 8'h04;
   localparam logic [7:0] OFF_CFG  = 8'h08;
   localparam logic [7:0] OFF_COPY = 8'h0c;
   localparam logic [7:0] OFF_RES  = 8'h10;
   localparam logic [2:0] CLK_PAGE = 3'h1;

   // ---------------------------------------------------------------
   // Control word bits and reset values
   // ---------------------------------------------------------------
   localparam int B_DISP  = 15;
   localparam int B_BZC   = 13;
   localparam int B_BZI   = 12;
   localparam int B_HIST  = 11;
   localparam int B_COL   = 10;
   localparam int B_MODE  = 8;
   localparam int B_PRINT = 7;
   localparam int B_WIN   = 6;
   localparam int B_INP   = 5;
   localparam logic [15:0] CTRL_RST = 16'h0000;
   localparam logic [1:0]  CFG_RST  = 2'h1;

   // ---------------------------------------------------------------
   // Memory table entries and clock field limits
   // ---------------------------------------------------------------
   localparam logic [8:0] ENT_CLK_FIRST = 9'h0f7;
   localparam logic [8:0] ENT_CLK_LAST  = 9'h0fd;
   localparam logic [8:0] ENT_SET_LAST  = 9'h0ff;
   localparam logic [7:0] SEC_MAX  = 8'h3b;
   localparam logic [7:0] HOUR_MAX = 8'h17;
   localparam logic [7:0] MON_MAX  = 8'h0c;
   localparam logic [7:0] YEAR_MAX = 8'h63;
   localparam logic [7:0] DOW_MAX  = 8'h06;

   typedef enum logic [1:0] {BZ_OFF, BZ_CONT, BZ_INTER} tscw_buzz_t;

endpackage : tscw_pkg

// *** hw/tscw_clock_table.sv ***
// Timekeeper holding the read-only clock entries of the memory table.
// Assumes the parent reads the entries as a packed array; no write port.
`timescale 1ns/100ps
module tscw_clock_table
   import tscw_pkg::*;
#(
   parameter int TICK_N = TICK_CYCLES
)(
   input  wire logic            hclk,
   input  wire logic            hresetn,
   output logic      [6:0][7:0] entries
);

   logic [TICK_W-1:0] tick_cnt_reg;
   logic              tick_reg;
   logic [7:0]        sec_reg, min_reg, hour_reg, date_reg;
   logic [7:0]        month_reg, year_reg, dow_reg, dim;
   logic              c_min, c_hour, c_day, c_mon;

   // ---------------------------------------------------------------
   // Seconds prescaler.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_reg <= '0;
         tick_reg     <= 1'b0;
      end else begin
         tick_reg <= (tick_cnt_reg == TICK_W'(TICK_N - 1));
         if (tick_cnt_reg == TICK_W'(TICK_N - 1)) begin
            tick_cnt_reg <= '0;
         end else begin
            tick_cnt_reg <= tick_cnt_reg + 1'b1;
         end
      end
   end

   always_comb begin
      case (month_reg)
         8'h04, 8'h06, 8'h09, 8'h0b: dim = 8'h1e;
         8'h02: dim = (year_reg[1:0] == 2'h0) ? 8'h1d : 8'h1c;
         default: dim = 8'h1f;
      endcase
   end

   assign c_min  = tick_reg && (sec_reg == SEC_MAX);
   assign c_hour = c_min && (min_reg == SEC_MAX);
   assign c_day  = c_hour && (hour_reg == HOUR_MAX);
   assign c_mon  = c_day && (date_reg == dim);

   // ---------------------------------------------------------------
   // Time fields, advanced by the timekeeper only.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sec_reg   <= 8'h00;
         min_reg   <= 8'h00;
         hour_reg  <= 8'h00;
         date_reg  <= 8'h01;
         month_reg <= 8'h01;
         year_reg  <= 8'h00;
         dow_reg   <= 8'h00;
      end else begin
         if (tick_reg) sec_reg <= c_min ? 8'h00 : sec_reg + 8'h01;
         if (c_min) min_reg <= c_hour ? 8'h00 : min_reg + 8'h01;
         if (c_hour) hour_reg <= c_day ? 8'h00 : hour_reg + 8'h01;
         if (c_day) begin
            date_reg <= c_mon ? 8'h01 : date_reg + 8'h01;
            dow_reg  <= (dow_reg == DOW_MAX) ? 8'h00 : dow_reg + 8'h01;
         end
         if (c_mon) begin
            month_reg <= (month_reg == MON_MAX) ? 8'h01 : month_reg + 8'h01;
            if (month_reg == MON_MAX) begin
               year_reg <= (year_reg == YEAR_MAX) ? 8'h00 : year_reg + 8'h01;
            end
         end
      end
   end

   assign entries = {dow_reg, year_reg, month_reg, date_reg,
                     hour_reg, min_reg, sec_reg};

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sec_by_tick_a: assert property ($changed(sec_reg) |-> $past(tick_reg))
      else $error("second entry changed without a timekeeper tick");
   min_carry_a: assert property (
      $changed(entries[1]) |-> $past(tick_reg && entries[0] == SEC_MAX))
      else $error("minute entry changed without a seconds carry");

endmodule : tscw_clock_table

// *** hw/tscw_top.sv ***
// Terminal status control word with its AHB-Lite register slave.
// Assumes a single-slave AHB-Lite bus and asynchronous pins for printer
// busy, buzzer-stop key, window-opening key and entry key.
`timescale 1ns/100ps
module tscw_top
   import tscw_pkg::*;
#(
   parameter int TICK_N  = TICK_CYCLES,
   parameter int BLINK_N = BLINK_CYCLES
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic [31:0]      hrdata,
   output logic             hresp,
   input  wire logic        print_busy_in,
   input  wire logic        stop_key_in,
   input  wire logic        window_key_in,
   input  wire logic        entry_key_in,
   output logic             history_clear,
   output logic             print_start,
   output logic             bl_white,
   output logic             bl_red,
   output logic             buzzer,
   output logic             window_close,
   output logic             window_open,
   output logic             entry_lock,
   output logic             entry_accept,
   output logic             copy_valid,
   output logic [8:0]       copy_entry,
   output logic [7:0]       copy_data
);

   logic [3:0]         pins, s1_reg, s2_reg, s3_reg;
   logic               busy_s, stop_rise, win_rise, ent_rise;
   logic               wr_pend_reg, rd_go;
   logic [7:0]         a_addr_reg;
   logic [31:0]        rd_val;
   logic [15:0]        ctrl_reg, new_ctrl, rise;
   logic [1:0]         cfg_reg;
   logic               seen_reg, ctrl_wr, cfg_wr, copy_wr;
   logic               print_pend_reg, blink_reg;
   logic [BLINK_W-1:0] blink_cnt_reg;
   tscw_buzz_t         buzz_reg;
   logic [6:0][7:0]    entries;
   logic [8:0]         src, dst;
   logic               copy_ok;
   logic [7:0]         src_val;
   logic               done_reg, err_reg;

   // ---------------------------------------------------------------
   // Pin synchronisers.
   // ---------------------------------------------------------------
   assign pins = {entry_key_in, window_key_in, stop_key_in, print_busy_in};

   for (genvar i = 0; i < 4; i++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
         if (!hresetn) begin
            s1_reg[i] <= 1'b0;
            s2_reg[i] <= 1'b0;
            s3_reg[i] <= 1'b0;
         end else begin
            s1_reg[i] <= pins[i];
            s2_reg[i] <= s1_reg[i];
            s3_reg[i] <= s2_reg[i];
         end
      end
   end

   assign busy_s    = s2_reg[0];
   assign stop_rise = s2_reg[1] && !s3_reg[1];
   assign win_rise  = s2_reg[2] && !s3_reg[2];
   assign ent_rise  = s2_reg[3] && !s3_reg[3];

   // ---------------------------------------------------------------
   // AHB-Lite slave: zero wait states, always OKAY.
   // ---------------------------------------------------------------
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign rd_go     = hsel && htrans[1] && hready && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         a_addr_reg  <= 8'h00;
      end else begin
         wr_pend_reg <= hsel && htrans[1] && hready && hwrite;
         if (hsel && htrans[1] && hready) a_addr_reg <= haddr[7:0];
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      if (haddr[7:5] == CLK_PAGE && haddr[4:2] != 3'h7) begin
         rd_val[7:0] = entries[haddr[4:2]];
      end else begin
         case (haddr[7:0])
            OFF_CTRL: rd_val[15:0] = ctrl_reg;
            OFF_STAT: rd_val[7:0] = {1'b0, buzzer, bl_red, bl_white,
                                     buzz_reg, busy_s, print_pend_reg};
            OFF_CFG:  rd_val[1:0] = cfg_reg;
            OFF_RES:  rd_val = {7'h00, copy_entry, copy_data, 6'h00,
                                err_reg, done_reg};
            default:  rd_val = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (rd_go) begin
         hrdata <= rd_val;
      end
   end

   assign ctrl_wr  = wr_pend_reg && (a_addr_reg == OFF_CTRL);
   assign cfg_wr   = wr_pend_reg && (a_addr_reg == OFF_CFG);
   assign copy_wr  = wr_pend_reg && (a_addr_reg == OFF_COPY);
   assign new_ctrl = hwdata[15:0];
   assign rise     = seen_reg ? (new_ctrl & ~ctrl_reg) : 16'h0000;

   // ---------------------------------------------------------------
   // Control word and configuration.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RST;
         seen_reg <= 1'b0;
      end else if (ctrl_wr) begin
         ctrl_reg <= new_ctrl;
         seen_reg <= 1'b1;
      end else begin
         if (history_clear) ctrl_reg[B_HIST] <= 1'b0;
         if (print_pend_reg && busy_s) ctrl_reg[B_PRINT] <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_reg <= CFG_RST;
      end else if (cfg_wr) begin
         cfg_reg <= hwdata[1:0];
      end
   end

   // ---------------------------------------------------------------
   // History clear and screen printing.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         history_clear  <= 1'b0;
         print_start    <= 1'b0;
         print_pend_reg <= 1'b0;
      end else begin
         history_clear <= ctrl_wr && rise[B_HIST];
         print_start   <= ctrl_wr && rise[B_PRINT];
         if (ctrl_wr && rise[B_PRINT]) begin
            print_pend_reg <= 1'b1;
         end else if (busy_s) begin
            print_pend_reg <= 1'b0;
         end
      end
   end

   // ---------------------------------------------------------------
   // Flash timebase shared by backlight and intermittent buzzer.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         blink_cnt_reg <= '0;
         blink_reg     <= 1'b0;
      end else if (blink_cnt_reg == BLINK_W'(BLINK_N - 1)) begin
         blink_cnt_reg <= '0;
         blink_reg     <= !blink_reg;
      end else begin
         blink_cnt_reg <= blink_cnt_reg + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // Backlight.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bl_white <= 1'b0;
         bl_red   <= 1'b0;
      end else if (!ctrl_reg[B_DISP]) begin
         bl_white <= 1'b0;
         bl_red   <= 1'b0;
      end else if (cfg_reg[1]) begin
         bl_white <= ctrl_reg[B_MODE] || blink_reg;
         bl_red   <= 1'b0;
      end else begin
         bl_white <= !ctrl_reg[B_COL] && (ctrl_reg[B_MODE] || blink_reg);
         bl_red   <= ctrl_reg[B_COL] && (ctrl_reg[B_MODE] || blink_reg);
      end
   end

   // ---------------------------------------------------------------
   // Buzzer.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buzz_reg <= BZ_OFF;
      end else if (ctrl_wr && new_ctrl[B_BZC:B_BZI] != ctrl_reg[B_BZC:B_BZI])
      begin
         if (new_ctrl[B_BZC]) begin
            buzz_reg <= BZ_CONT;
         end else if (new_ctrl[B_BZI]) begin
            buzz_reg <= BZ_INTER;
         end else begin
            buzz_reg <= BZ_OFF;
         end
      end else if (stop_rise) begin
         buzz_reg <= BZ_OFF;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         buzzer <= 1'b0;
      end else begin
         case (buzz_reg)
            BZ_CONT:  buzzer <= cfg_reg[0];
            BZ_INTER: buzzer <= cfg_reg[0] && blink_reg;
            default:  buzzer <= 1'b0;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Window and entry locks.
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         window_close <= 1'b0;
         window_open  <= 1'b0;
         entry_lock   <= 1'b0;
         entry_accept <= 1'b0;
      end else begin
         window_close <= ctrl_reg[B_WIN];
         window_open  <= win_rise && !ctrl_reg[B_WIN];
         entry_lock   <= ctrl_reg[B_INP];
         entry_accept <= ent_rise && !ctrl_reg[B_INP];
      end
   end

   // ---------------------------------------------------------------
   // Entry copy out of the clock table.
   // ---------------------------------------------------------------
   tscw_clock_table #(
      .TICK_N (TICK_N)
   ) u_clock (
      .hclk    (hclk),
      .hresetn (hresetn),
      .entries (entries)
   );

   assign src     = hwdata[8:0];
   assign dst     = hwdata[24:16];
   assign copy_ok = copy_wr && src >= ENT_CLK_FIRST && src <= ENT_CLK_LAST
                    && !(dst >= ENT_CLK_FIRST && dst <= ENT_SET_LAST);
   assign src_val = entries[3'(src - ENT_CLK_FIRST)];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         copy_valid <= 1'b0;
         copy_entry <= 9'h000;
         copy_data  <= 8'h00;
         done_reg   <= 1'b0;
         err_reg    <= 1'b0;
      end else begin
         copy_valid <= copy_ok;
         if (copy_ok) begin
            copy_entry <= dst;
            copy_data  <= src_val;
         end
         if (copy_wr) begin
            done_reg <= copy_ok;
            err_reg  <= !copy_ok;
         end
      end
   end

   // ---------------------------------------------------------------
   // Checks.
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence hist_req_s;
      ctrl_wr && rise[B_HIST] ##1 !ctrl_wr;
   endsequence
   sequence print_req_s;
      ctrl_wr && rise[B_PRINT];
   endsequence

   hist_clear_a: assert property (hist_req_s |->
      history_clear ##1 !ctrl_reg[B_HIST] && !history_clear)
      else $error("history clear pulse or bit return wrong");
   mono_light_a: assert property (ctrl_reg[B_DISP] && !cfg_reg[1] |=>
      bl_red == ($past(ctrl_reg[B_COL]) &&
                 ($past(ctrl_reg[B_MODE]) || $past(blink_reg))))
      else $error("monochrome backlight decode wrong");
   colour_light_a: assert property (ctrl_reg[B_DISP] && cfg_reg[1] |=>
      !bl_red && bl_white == ($past(ctrl_reg[B_MODE]) || $past(blink_reg)))
      else $error("colour backlight decode wrong");
   light_off_a: assert property (!ctrl_reg[B_DISP] |=> !bl_white && !bl_red)
      else $error("backlight lit with display bit clear");
   print_go_a: assert property (print_req_s |=>
      print_start && print_pend_reg ##1 !print_start)
      else $error("print start not a single pulse");
   print_ret_a: assert property (print_pend_reg && busy_s && !ctrl_wr
      |=> !ctrl_reg[B_PRINT] && !print_pend_reg)
      else $error("print bit not returned after busy");
   window_lock_a: assert property (ctrl_reg[B_WIN] |=>
      window_close && !window_open)
      else $error("window opened while locked");
   entry_lock_a: assert property (ctrl_reg[B_INP] |=>
      entry_lock && !entry_accept)
      else $error("entry accepted while locked");
   change_only_a: assert property (history_clear || print_start |->
      $past(ctrl_wr) && $past(seen_reg))
      else $error("action without a later change of the word");
   buzz_off_a: assert property (ctrl_wr && ctrl_reg[B_BZC:B_BZI] != 2'h0
      && new_ctrl[B_BZC:B_BZI] == 2'h0 |=> buzz_reg == BZ_OFF ##1 !buzzer)
      else $error("buzzer not stopped by clearing both bits");
   key_stop_a: assert property (stop_rise && !ctrl_wr |=>
      buzz_reg == BZ_OFF ##1 !buzzer)
      else $error("buzzer-stop key ignored");
   buzz_gate_a: assert property (!cfg_reg[0] |=> !buzzer)
      else $error("buzzer sounds while switch forbids it");
   buzz_prio_a: assert property (ctrl_wr && new_ctrl[B_BZC] &&
      new_ctrl[B_BZI] && !ctrl_reg[B_BZC] |=> buzz_reg == BZ_CONT)
      else $error("intermittent tone chosen over continuous");
   copy_out_a: assert property (copy_ok |=> copy_valid &&
      copy_data == $past(src_val) && copy_entry == $past(dst))
      else $error("copied value not placed in mapped word");
   copy_guard_a: assert property (copy_wr && dst >= ENT_CLK_FIRST &&
      dst <= ENT_SET_LAST |=> !copy_valid && err_reg)
      else $error("copy into a clock entry not refused");

endmodule : tscw_top

// *** bench/tscw_host.sv ***
// Host controller model: an AHB-Lite master on the register bus.
// Assumes one slave whose hreadyout is fed back as the bus hready.
`timescale 1ns/100ps
module tscw_host (
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel = 1'b0,
   output logic [31:0]      haddr = 32'h0,
   output logic [1:0]       htrans = 2'h0,
   output logic             hwrite = 1'b0,
   output logic [31:0]      hwdata = 32'h0
);
   // Single word transfer; the caller picks the order and spacing.
   task automatic xfer(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic to);
      int n;
      n = 0;
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do begin
         @(posedge hclk);
         n++;
      end while (!hready && n < 64);
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (!hready && n < 128);
      q = hrdata;
      to = !hready;
   endtask : xfer
endmodule : tscw_host

// *** bench/tscw_top_tb.sv ***
// Self-checking bench of the terminal status control word.
// Assumes the host model as bus master and short timekeeper counts.
`timescale 1ns/100ps
module tscw_top_tb
   import tscw_pkg::*;
;
   logic        hclk = 1'b0, hresetn = 1'b0;
   logic        hsel, hwrite, hreadyout, print_busy_in = 1'b0;
   logic        hresp;
   logic        stop_key_in = 1'b0, window_key_in = 1'b0, entry_key_in = 1'b0;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata;
   logic        history_clear, print_start, bl_white, bl_red, buzzer;
   logic        window_close, window_open, entry_lock, entry_accept;
   logic        copy_valid;
   logic [8:0]  copy_entry;
   logic [7:0]  copy_data;
   int          error_cnt = 0, compares = 0, cyc = 0;
   int          n_hc = 0, n_ps = 0, n_cv = 0, n_wo = 0, n_ea = 0;
   logic [31:0] bl [7] = '{32'h01800040, 32'h01810080, 32'h01840004,
      32'h01850008, 32'h01050000, 32'h03840040, 32'h03850080};

   tscw_host i_tscw_host (.hclk, .hready(hreadyout), .hrdata, .hsel,
      .haddr, .htrans, .hwrite, .hwdata);
   tscw_top #(.TICK_N(20), .BLINK_N(4)) i_tscw_top (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .print_busy_in, .stop_key_in, .window_key_in, .entry_key_in,
      .history_clear, .print_start, .bl_white, .bl_red, .buzzer,
      .window_close, .window_open, .entry_lock, .entry_accept,
      .copy_valid, .copy_entry, .copy_data);

   // ---------------------------------------------------------------
   // Clock, cycle count and pulse counters
   // ---------------------------------------------------------------
   initial forever #2 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc = hresetn ? cyc + 1 : 0;
      n_hc += history_clear;
      n_ps += print_start;
      n_cv += copy_valid;
      n_wo += window_open;
      n_ea += entry_accept;
   end

   // ---------------------------------------------------------------
   // Tasks
   // ---------------------------------------------------------------
   task automatic tally_and_finish();
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input string s, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
      logic to;
      i_tscw_host.xfer(w, a, d, q, to);
      if (to) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr
   task automatic rc(input string s, input logic [7:0] a,
                     input logic [31:0] m, e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(s, q & m, e);
   endtask : rc
   task automatic ones(output int w, r, b);
      w = 0;
      r = 0;
      b = 0;
      repeat (2) @(posedge hclk);
      repeat (8) begin
         @(posedge hclk);
         w += bl_white;
         r += bl_red;
         b += buzzer;
      end
   endtask : ones
   task automatic key(input logic [2:0] k);
      {stop_key_in, window_key_in, entry_key_in} <= k;
      repeat (6) @(posedge hclk);
      {stop_key_in, window_key_in, entry_key_in} <= 3'h0;
      repeat (6) @(posedge hclk);
   endtask : key

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int w, r, b;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rc("ctrl", OFF_CTRL, '1, 32'h0);
      rc("cfg", OFF_CFG, '1, 32'h1);
      rc("unmapped", 8'h40, '1, 32'h0);
      chk("hresp", hresp, 0);
      wr(OFF_CTRL, 32'h0880);
      repeat (3) @(posedge hclk);
      chk("baseline", n_hc + n_ps, 0);
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, 32'h0800);
      repeat (3) @(posedge hclk);
      chk("history", n_hc, 1);
      rc("ctrl", OFF_CTRL, '1, 32'h0);
      rc("busy", OFF_STAT, 32'h2, 32'h0);
      wr(OFF_CTRL, 32'h0080);
      repeat (3) @(posedge hclk);
      chk("print", n_ps, 1);
      rc("ctrl", OFF_CTRL, '1, 32'h80);
      print_busy_in <= 1'b1;
      repeat (6) @(posedge hclk);
      rc("ctrl", OFF_CTRL, '1, 32'h0);
      print_busy_in <= 1'b0;
      repeat (4) @(posedge hclk);
      rc("busy", OFF_STAT, 32'h2, 32'h0);
      wr(OFF_CTRL, 32'h0080);
      repeat (3) @(posedge hclk);
      chk("print again", n_ps, 2);
      $display("test control done");
      foreach (bl[i]) begin
         wr(OFF_CFG, {24'h0, bl[i][31:24]});
         wr(OFF_CTRL, {16'h0, bl[i][23:8]});
         ones(w, r, b);
         chk("white", w, bl[i][7:4]);
         chk("red", r, bl[i][3:0]);
      end
      wr(OFF_CFG, 32'h1);
      wr(OFF_CTRL, 32'h3000);
      ones(w, r, b);
      chk("buzz cont", b, 8);
      rc("buzz state", OFF_STAT, 32'hc, 32'h4);
      wr(OFF_CTRL, 32'h1000);
      ones(w, r, b);
      chk("buzz inter", b, 4);
      key(3'h4);
      rc("buzz stop", OFF_STAT, 32'h4c, 32'h0);
      wr(OFF_CTRL, 32'h2000);
      wr(OFF_CFG, 32'h0);
      ones(w, r, b);
      chk("buzz masked", b, 0);
      rc("buzz state", OFF_STAT, 32'hc, 32'h4);
      wr(OFF_CTRL, 32'h0);
      rc("buzz off", OFF_STAT, 32'hc, 32'h0);
      $display("test lamp and buzzer done");
      wr(OFF_CTRL, 32'h0040);
      key(3'h2);
      chk("win close", {window_close, n_wo[3:0]}, 5'h10);
      wr(OFF_CTRL, 32'h0020);
      key(3'h3);
      chk("win open", n_wo, 1);
      chk("entry lock", {entry_lock, n_ea[3:0]}, 5'h10);
      wr(OFF_CTRL, 32'h0);
      key(3'h1);
      chk("entry", n_ea, 1);
      $display("test locks done");
      while (cyc < 1500) @(posedge hclk);
      wr(8'h24, 32'h33);
      rc("minutes", 8'h24, '1, 32'h1);
      rc("hours", 8'h28, '1, 32'h0);
      wr(OFF_COPY, 32'h010200f8);
      repeat (3) @(posedge hclk);
      chk("copy min", {n_cv[3:0], copy_entry, copy_data}, 21'h30201);
      repeat (20) @(posedge hclk);
      wr(OFF_COPY, 32'h010300f9);
      repeat (3) @(posedge hclk);
      chk("copy hour", {n_cv[3:0], copy_entry, copy_data}, 21'h50300);
      wr(OFF_COPY, 32'h00f900f8);
      repeat (3) @(posedge hclk);
      chk("copy refused", n_cv, 2);
      rc("copy result", OFF_RES, 32'h3, 32'h2);
      $display("test clock done");
      tally_and_finish();
   end
endmodule : tscw_top_tb
